// ### rtl/tagd_guard.sv
// Command interpreter of a contactless tag: password guard, counters,
// signature, virtual select. Link pins are asynchronous to clock.
`timescale 1ns/1ns
module tagd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clock, // core clock
  input wire logic rst, // async reset
  input wire logic inValid, // write request
  output logic inReady, // room left
  input wire logic [WIDTH-1:0] inData, // write word
  output logic outValid, // word waiting
  input wire logic outReady, // read request
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, rdPtr_q;
  assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always_ff @(posedge clock) begin
    if (inValid && inReady) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

module tagd_guard import tagd_pkg::*; #(
  parameter int FDT_CYCLES = FDT_CYC,
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [255:0] SIG_VALUE = {8{32'h5A3C0F96}} // Arbitrary value
) (
  input wire logic clock, // 125 MHz core clock
  input wire logic rst, // field reset, async high
  input wire logic linkClk, // byte clock, rising edge
  input wire logic [7:0] linkData, // received byte
  input wire logic linkFrame, // high during reader frame
  input wire logic linkErr, // parity or CRC error seen
  input wire logic replyReady, // front end takes bytes
  output logic replyValid, // reply byte available
  output tagd_word_s replyWord, // reply byte and flags
  output logic sessionAuth, // verified session
  output logic accessLocked, // attempts exhausted
  output logic protectActive // password guard enabled
);
  logic [2:0] clkSync_q, frmSync_q;
  logic [1:0] errSync_q, rdySync_q;
  logic [7:0] datA_q, datB_q;
  logic [7:0] rxBuf_q [6];
  logic [2:0] rxCnt_q;
  logic rxErr_q;
  tagd_ses_e ses_q;
  tagd_phase_e phase_q;
  tagd_kind_e kind_q, exKind;
  logic [5:0] len_q, idx_q, exLen;
  logic [3:0] code_q, exCode;
  logic [7:0] startPage_q, access_q, cardType_q, rdPage_q, rdLim_q;
  logic [31:0] password_q;
  logic [15:0] passAck_q;
  logic [23:0] cnt_q [3];
  logic [1:0] cntSel_q;
  logic [2:0] failCnt_q;
  logic locked_q;
  logic [31:0] user_q [PAGE_CFG0];
  logic [15:0] fdtCnt_q;
  logic fdtDone;
  logic exReply, doSel, doHalt, doOk, doFail, doWrite, doIncr;
  logic byteStb, frmStart, frmEnd, authed, protOn, writeProt, incOvf;
  logic [7:0] cmd, arg, rdLim;
  logic [31:0] rxWord, pageWord;
  logic [24:0] incSum;
  tagd_word_s pushWord, headWord;
  logic pushReady, headValid;

  // Two stages before any logic; data is stable across the rising edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clkSync_q <= '0;
      frmSync_q <= '0;
      errSync_q <= '0;
      rdySync_q <= '0;
      datA_q <= '0;
      datB_q <= '0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], linkClk};
      frmSync_q <= {frmSync_q[1:0], linkFrame};
      errSync_q <= {errSync_q[0], linkErr};
      rdySync_q <= {rdySync_q[0], replyReady};
      datA_q <= linkData;
      datB_q <= datA_q;
    end
  end
  assign byteStb = clkSync_q[1] && !clkSync_q[2] && frmSync_q[1];
  assign frmStart = frmSync_q[1] && !frmSync_q[2];
  assign frmEnd = !frmSync_q[1] && frmSync_q[2];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxCnt_q <= '0;
      rxErr_q <= 1'b0;
      for (int i = 0; i < 6; i++) rxBuf_q[i] <= '0;
    end else if (frmStart) begin
      rxCnt_q <= '0;
      rxErr_q <= 1'b0;
    end else begin
      if (byteStb && rxCnt_q < 3'd6) begin
        rxBuf_q[rxCnt_q] <= datB_q;
        rxCnt_q <= rxCnt_q + 3'd1;
      end
      if (frmEnd) rxErr_q <= errSync_q[1];
    end
  end

  assign cmd = rxBuf_q[0];
  assign arg = rxBuf_q[1];
  assign rxWord = {rxBuf_q[5], rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]};
  assign authed = ses_q == SES_AUTH;
  assign protOn = startPage_q <= PAGE_LAST;
  assign writeProt = protOn && arg >= startPage_q && !authed;
  assign rdLim = (protOn && access_q[ACC_LEVEL] && !authed) ? startPage_q : PAGE_LAST + 8'd1;
  assign incSum = {1'b0, cnt_q[arg[1:0]]} + {1'b0, rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]};
  // Carry out means overflow; zero never carries
  assign incOvf = incSum[24];

  always_comb begin
    exReply = 1'b1;
    exKind = RK_NIB;
    exLen = 6'd1;
    exCode = ACK;
    doSel = 1'b0;
    doHalt = 1'b0;
    doOk = 1'b0;
    doFail = 1'b0;
    doWrite = 1'b0;
    doIncr = 1'b0;
    if (ses_q == SES_IDLE) begin
      if ((cmd == CMD_REQ || cmd == CMD_WAKE) && !rxErr_q) begin
        exKind = RK_ATQA;
        exLen = 6'd2;
      end else if (cmd == CMD_SEL2 && arg == SEL_NVB && !rxErr_q) begin
        exKind = RK_SAK;
        doSel = 1'b1;
      end else begin
        exReply = 1'b0;
      end
    end else if (rxErr_q) begin
      exCode = NAK_CRC;
    end else begin
      case (cmd)
        CMD_HALT: begin
          exReply = 1'b0;
          doHalt = 1'b1;
        end
        CMD_PASS_VERIFY: begin
          // Compare LSB first; lock fails all
          if (locked_q || {rxBuf_q[4], rxBuf_q[3], rxBuf_q[2], rxBuf_q[1]} != password_q) begin
            exCode = NAK_OTHER;
            doFail = 1'b1;
          end else begin
            exKind = RK_PASS_ACK;
            exLen = 6'd2;
            doOk = 1'b1;
          end
        end
        CMD_CNT_RD: begin
          if (arg >= CNT_NUM) exCode = NAK_ARG;
          else begin
            exKind = RK_CNT;
            exLen = 6'd3;
          end
        end
        CMD_CNT_INC: begin
          if (arg >= CNT_NUM || rxCnt_q < 3'd6) exCode = NAK_ARG;
          else if (incOvf) exCode = NAK_OVF;
          else doIncr = 1'b1;
        end
        CMD_SIG: begin
          if (arg != 8'h00) exCode = NAK_ARG;
          else begin
            exKind = RK_SIG;
            exLen = LEN_SIG;
          end
        end
        CMD_VSEL_LAST: exKind = RK_VCT;
        CMD_READ: begin
          if (arg >= rdLim) exCode = NAK_ARG;
          else begin
            exKind = RK_PAGE;
            exLen = LEN_READ;
          end
        end
        CMD_WRITE: begin
          if (arg < PAGE_FIRST_WR || arg > PAGE_LAST || rxCnt_q < 3'd6 || writeProt) begin
            exCode = NAK_ARG;
          end else if (access_q[ACC_LOCK] && (arg == PAGE_CFG0 || arg == PAGE_CFG1)) begin
            exCode = NAK_ARG;
          end else begin
            doWrite = 1'b1;
          end
        end
        default: exCode = NAK_ARG;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) ses_q <= SES_IDLE;
    else if (phase_q == PH_EXEC) begin
      if (doSel) ses_q <= SES_ACTIVE;
      else if (doHalt) ses_q <= SES_IDLE;
      else if (doOk) ses_q <= SES_AUTH;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      failCnt_q <= '0;
      locked_q <= 1'b0;
    end else if (phase_q == PH_EXEC) begin
      if (doOk) failCnt_q <= '0;
      else if (doFail && access_q[2:0] != 3'd0) begin
        if (failCnt_q == access_q[2:0]) locked_q <= 1'b1;
        else failCnt_q <= failCnt_q + 3'd1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) cnt_q[i] <= CNT_RST;
    end else if (phase_q == PH_EXEC && doIncr) begin
      cnt_q[arg[1:0]] <= incSum[23:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startPage_q <= START_PAGE_RST;
      access_q <= ACCESS_RST;
      cardType_q <= CARD_TYPE_RST;
      password_q <= PASSWORD_RST;
      passAck_q <= PASS_ACK_RST;
    end else if (phase_q == PH_EXEC && doWrite) begin
      case (arg)
        PAGE_CFG0: startPage_q <= rxWord[31:24];
        PAGE_CFG1: begin
          access_q <= rxWord[7:0];
          cardType_q <= rxWord[15:8];
        end
        PAGE_PASSWORD: password_q <= rxWord;
        PAGE_PASS_ACK: passAck_q <= rxWord[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (phase_q == PH_EXEC && doWrite && arg < PAGE_CFG0) user_q[arg[5:0]] <= rxWord;
  end

  always_comb begin
    pageWord = 32'h0;
    if (rdPage_q < PAGE_CFG0) pageWord = user_q[rdPage_q[5:0]];
    else if (rdPage_q == PAGE_CFG0) pageWord = {startPage_q, 24'h0};
    else if (rdPage_q == PAGE_CFG1) pageWord = {16'h0, cardType_q, access_q};
  end

  always_comb begin
    pushWord.last = idx_q == len_q - 6'd1;
    pushWord.nibble = kind_q == RK_NIB;
    case (kind_q)
      RK_NIB: pushWord.data = {4'h0, code_q};
      RK_ATQA: pushWord.data = (idx_q == 6'd0) ? ATQA_LO : ATQA_HI;
      RK_SAK: pushWord.data = SAK_VAL;
      RK_PASS_ACK: pushWord.data = passAck_q[{idx_q[0], 3'b000} +: 8];
      RK_CNT: pushWord.data = cnt_q[cntSel_q][{idx_q[1:0], 3'b000} +: 8];
      RK_SIG: pushWord.data = SIG_VALUE[{idx_q[4:0], 3'b000} +: 8];
      RK_VCT: pushWord.data = cardType_q;
      RK_PAGE: pushWord.data = pageWord[{idx_q[1:0], 3'b000} +: 8];
      default: pushWord.data = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      kind_q <= RK_NIB;
      len_q <= 6'd1;
      code_q <= ACK;
      idx_q <= '0;
      cntSel_q <= '0;
      rdPage_q <= '0;
      rdLim_q <= '0;
    end else begin
      case (phase_q)
        PH_IDLE: if (frmEnd && rxCnt_q != 3'd0) phase_q <= PH_EXEC;
        PH_EXEC: begin
          phase_q <= exReply ? PH_SEND : PH_IDLE;
          kind_q <= exKind;
          len_q <= exLen;
          code_q <= exCode;
          idx_q <= '0;
          cntSel_q <= arg[1:0];
          rdPage_q <= arg;
          rdLim_q <= rdLim;
        end
        PH_SEND: if (pushReady) begin
          idx_q <= idx_q + 6'd1;
          // Read wraps to page 0 at the readable limit
          if (idx_q[1:0] == 2'd3) begin
            rdPage_q <= (rdPage_q + 8'd1 >= rdLim_q) ? 8'h00 : rdPage_q + 8'd1;
          end
          if (pushWord.last) phase_q <= PH_IDLE;
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Frame delay, counted from the end of the reader frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) fdtCnt_q <= '0;
    else if (frmStart || frmEnd) fdtCnt_q <= '0;
    else if (!frmSync_q[1] && !fdtDone) fdtCnt_q <= fdtCnt_q + 16'd1;
  end
  assign fdtDone = fdtCnt_q == 16'(FDT_CYCLES);

  // Stalls the byte generator when the front end is slow
  tagd_fifo #(.WIDTH($bits(tagd_word_s)), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(phase_q == PH_SEND),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(headValid),
    .outReady(rdySync_q[1] && fdtDone),
    .outData(headWord)
  );
  assign replyValid = headValid && fdtDone;
  assign replyWord = headWord;
  assign sessionAuth = authed;
  assign accessLocked = locked_q;
  assign protectActive = protOn;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence sExecSend;
    phase_q == PH_EXEC ##1 phase_q == PH_SEND;
  endsequence
  a_reply_delay: assert property (
    replyValid |-> fdtCnt_q == 16'(FDT_CYCLES) && !frmSync_q[1] && !frmEnd)
    else $error("reply before frame delay");
  a_guard_off: assert property (startPage_q > PAGE_LAST |-> !protectActive)
    else $error("guard active with start page out of range");
  a_open_write: assert property (
    phase_q == PH_EXEC && ses_q != SES_IDLE && !rxErr_q && cmd == CMD_WRITE
    && rxCnt_q == 3'd6 && startPage_q > PAGE_LAST
    && (arg == PAGE_PASSWORD || arg == PAGE_PASS_ACK) |-> doWrite)
    else $error("open password page write refused");
  a_ovf_nak: assert property (
    phase_q == PH_EXEC && ses_q != SES_IDLE && !rxErr_q && cmd == CMD_CNT_INC
    && arg < CNT_NUM && rxCnt_q == 3'd6
    && {1'b0, cnt_q[arg[1:0]]} + {1'b0, rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]} > 25'hFFFFFF
    |=> code_q == NAK_OVF && cnt_q[cntSel_q] == $past(cnt_q[arg[1:0]]))
    else $error("overflow changed counter or no NAK");
  a_inc_value: assert property (
    phase_q == PH_EXEC && doIncr
    |=> cnt_q[cntSel_q] == $past(cnt_q[arg[1:0]] + {rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]}))
    else $error("counter not incremented");
  a_locked_fail: assert property (locked_q |-> !doOk)
    else $error("verification passed while locked");
  a_fail_lock: assert property (
    phase_q == PH_EXEC && doFail && access_q[2:0] != 3'd0
    && failCnt_q == access_q[2:0] |=> locked_q)
    else $error("limit reached without lock");
  a_ok_clear: assert property (
    phase_q == PH_EXEC && doOk |=> failCnt_q == 3'd0 && sessionAuth)
    else $error("success did not clear count");
  a_pwd_hidden: assert property (
    phase_q == PH_SEND && kind_q == RK_PAGE
    && rdPage_q >= PAGE_PASSWORD |-> pushWord.data == 8'h00)
    else $error("password byte leaked");
  a_write_guard: assert property (
    phase_q == PH_EXEC && doWrite && protOn && arg >= startPage_q |-> authed)
    else $error("protected write unverified");
  a_atqa_reply: assert property (
    phase_q == PH_EXEC && ses_q == SES_IDLE && cmd == CMD_REQ
    && !rxErr_q |-> sExecSend ##0 kind_q == RK_ATQA && len_q == 6'd2)
    else $error("request not answered");
endmodule

// ### rtl/tagd_pkg.sv
// Shared constants and types of the tag access guard.
// Assumes a 125 MHz core clock and a field reset on rst.
package tagd_pkg;
  localparam logic [7:0] CMD_REQ = 8'h26;
  localparam logic [7:0] CMD_WAKE = 8'h52;
  localparam logic [7:0] CMD_SEL2 = 8'h95;
  localparam logic [7:0] SEL_NVB = 8'h70;
  localparam logic [7:0] CMD_HALT = 8'h50;
  localparam logic [7:0] CMD_READ = 8'h30;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] CMD_CNT_RD = 8'h39;
  localparam logic [7:0] CMD_CNT_INC = 8'hA5;
  localparam logic [7:0] CMD_PASS_VERIFY = 8'h1B;
  localparam logic [7:0] CMD_SIG = 8'h3C;
  localparam logic [7:0] CMD_VSEL_LAST = 8'h4B;
  localparam logic [3:0] ACK = 4'hA;
  localparam logic [3:0] NAK_ARG = 4'h0;
  localparam logic [3:0] NAK_CRC = 4'h1;
  localparam logic [3:0] NAK_OVF = 4'h4;
  localparam logic [3:0] NAK_OTHER = 4'h6;
  localparam logic [7:0] ATQA_LO = 8'h44;
  localparam logic [7:0] ATQA_HI = 8'h00;
  localparam logic [7:0] SAK_VAL = 8'h00;
  localparam logic [7:0] START_PAGE_RST = 8'hFF;
  localparam logic [7:0] ACCESS_RST = 8'h00;
  localparam logic [7:0] CARD_TYPE_RST = 8'h05;
  localparam logic [31:0] PASSWORD_RST = 32'hFFFFFFFF;
  localparam logic [15:0] PASS_ACK_RST = 16'h0000;
  localparam logic [23:0] CNT_RST = 24'h000000;
  localparam int ACC_LEVEL = 7;
  localparam int ACC_LOCK = 6;
  localparam logic [7:0] PAGE_FIRST_WR = 8'h02;
  localparam logic [7:0] PAGE_CFG0 = 8'h25;
  localparam logic [7:0] PAGE_CFG1 = 8'h26;
  localparam logic [7:0] PAGE_PASSWORD = 8'h27;
  localparam logic [7:0] PAGE_PASS_ACK = 8'h28;
  localparam logic [7:0] PAGE_LAST = 8'h28;
  localparam logic [7:0] CNT_NUM = 8'h03;
  localparam logic [5:0] LEN_SIG = 6'h20;
  localparam logic [5:0] LEN_READ = 6'h10;
  localparam int FDT_N = 9;
  localparam int FDT_CARRIER = FDT_N * 128 + 84;
  localparam int CARRIER_KHZ = 13560;
  localparam int CLK_KHZ = 125000;
  localparam int FDT_CYC = (FDT_CARRIER * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
  localparam int FIFO_DEPTH = 16;
  typedef struct packed {
    logic last;
    logic nibble;
    logic [7:0] data;
  } tagd_word_s;
  typedef enum logic [2:0] {SES_IDLE = 3'h1, SES_ACTIVE = 3'h2, SES_AUTH = 3'h4} tagd_ses_e;
  typedef enum logic [2:0] {PH_IDLE = 3'h1, PH_EXEC = 3'h2, PH_SEND = 3'h4} tagd_phase_e;
  typedef enum logic [7:0] {
    RK_NIB = 8'h01, RK_ATQA = 8'h02, RK_SAK = 8'h04, RK_PASS_ACK = 8'h08,
    RK_CNT = 8'h10, RK_SIG = 8'h20, RK_VCT = 8'h40, RK_PAGE = 8'h80
  } tagd_kind_e;
endpackage

// ### tb/tagd_reader.sv
// Reader-side model: sends command frames on the byte link, takes reply bytes.
// Assumes the block syncs linkClk and replyReady with two flops on clock.
`timescale 1ns/1ns
module tagd_reader import tagd_pkg::*; (
  input wire logic clock, // core clock
  output logic linkClk, // byte strobe
  output logic [7:0] linkData, // command byte
  output logic linkFrame, // frame envelope
  output logic linkErr, // parity or CRC fault
  output logic replyReady, // reply sink ready
  input wire logic replyValid, // reply byte offered
  input wire tagd_word_s replyWord // reply byte and flags
);
  tagd_word_s got[$];
  int sinceEnd = 0;
  int fdtSeen = -1;
  int stall = 0;
  logic [1:0] rdySync = 2'b00;
  initial begin
    linkClk = 1'b0;
    linkData = 8'h00;
    linkFrame = 1'b0;
    linkErr = 1'b0;
    replyReady = 1'b1;
  end
  // Mirror of the block's ready sync, so only bytes it really drains are logged
  always @(posedge clock) begin
    rdySync <= {rdySync[0], replyReady};
    replyReady <= (stall == 0);
    if (stall > 0)
      stall <= stall - 1;
    sinceEnd <= linkFrame ? 0 : sinceEnd + 1;
    if (replyValid && fdtSeen < 0)
      fdtSeen <= sinceEnd;
    if (replyValid && rdySync[1])
      got.push_back(replyWord);
  end
  // Fields go least significant byte first
  task automatic send(input logic [47:0] c, input int n, input logic e, input int s);
    fdtSeen = -1;
    stall = s;
    got.delete();
    linkFrame <= 1'b1;
    linkErr <= e;
    for (int i = 0; i < n; i++) begin
      linkData <= c[8*i +: 8];
      #40 linkClk <= 1'b1;
      #62 linkClk <= 1'b0;
      #23;
    end
    #40 linkFrame <= 1'b0;
    // Released data line shows the inverse, not a stale byte
    linkData <= ~linkData;
    #100 linkErr <= 1'b0;
  endtask
endmodule

// ### tb/tb_top.sv
// Top bench of the tag guard: reader model on the link, scenario tasks, verdict.
// Assumes the frame delay parameter is shortened to FDT_SIM cycles.
`timescale 1ns/1ns
module tb_top import tagd_pkg::*; ;
  localparam int FDT_SIM = 20;
  // Arbitrary signature pattern; distinct bytes expose order faults
  localparam logic [255:0] SIG_TB =
    256'h1F1E1D1C_1B1A1918_17161514_13121110_0F0E0D0C_0B0A0908_07060504_03020100;
  localparam logic [39:0] PW_OK = 40'h44332211_1B;
  localparam logic [39:0] PW_BAD = 40'h00000000_1B;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic linkClk;
  logic linkFrame;
  logic linkErr;
  logic replyReady;
  logic replyValid;
  logic [7:0] linkData;
  tagd_word_s replyWord;
  logic sessionAuth;
  logic accessLocked;
  logic protectActive;
  int mismatches = 0;
  int cmpCount = 0;
  always #4 clock = ~clock;
  tagd_guard #(.FDT_CYCLES(FDT_SIM), .SIG_VALUE(SIG_TB)) tagd_guard_i (
    .clock(clock), .rst(rst), .linkClk(linkClk), .linkData(linkData),
    .linkFrame(linkFrame), .linkErr(linkErr), .replyReady(replyReady),
    .replyValid(replyValid), .replyWord(replyWord), .sessionAuth(sessionAuth),
    .accessLocked(accessLocked), .protectActive(protectActive));
  tagd_reader tagd_reader_i (
    .clock(clock), .linkClk(linkClk), .linkData(linkData), .linkFrame(linkFrame),
    .linkErr(linkErr), .replyReady(replyReady), .replyValid(replyValid),
    .replyWord(replyWord));
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Negative count asks for one 4-bit code reply held in x[3:0]
  task automatic xact(input string nm, input logic [47:0] c, input int cn, input logic e,
      input logic [255:0] x, input int xn, input int s = 0);
    int k;
    int n;
    tagd_reader_i.send(c, cn, e, s);
    n = (xn < 0) ? 1 : xn;
    k = 0;
    // Always waits long enough to catch a reply that should not come
    while ((tagd_reader_i.got.size() < n || k < FDT_SIM + 40) && k < 800) begin
      @(posedge clock);
      k++;
    end
    if (k >= 800) begin
      mismatches++;
      $display("[FAIL] %s expected reply seen timeout", nm);
      stopTest();
    end
    check({nm, " length"}, n, tagd_reader_i.got.size());
    if (n > 0)
      check({nm, " delay"}, 1, tagd_reader_i.fdtSeen >= FDT_SIM + 2);
    for (int i = 0; i < n && i < tagd_reader_i.got.size(); i++) begin
      if (xn < 0)
        check(nm, {x[3:0], 2'b11}, {tagd_reader_i.got[i].data[3:0],
          tagd_reader_i.got[i].last, tagd_reader_i.got[i].nibble});
      else
        check(nm, {i == n - 1, 1'b0, x[8*i +: 8]}, tagd_reader_i.got[i]);
    end
  endtask
  task automatic nib(input string nm, input logic [47:0] c, input int cn, input logic [3:0] code);
    xact(nm, c, cn, 1'b0, code, -1);
  endtask
  task automatic act(input logic [7:0] wake);
    xact("request", wake, 1, 1'b0, 256'h0044, 2);
    xact("select", 48'h70_95, 2, 1'b0, 256'h00, 1);
  endtask
  task automatic tReset();
    check("sessionAuth", 1'b0, sessionAuth);
    check("accessLocked", 1'b0, accessLocked);
    check("protectActive", 1'b0, protectActive);
    check("replyValid", 1'b0, replyValid);
  endtask
  task automatic tCount();
    nib("incr five", 48'h00_000005_00_A5, 6, ACK);
    xact("read cnt0", 48'h00_39, 2, 1'b0, 256'h000005, 3);
    nib("incr to max", 48'h00_FFFFFA_00_A5, 6, ACK);
    nib("incr over", 48'h00_000001_00_A5, 6, NAK_OVF);
    nib("incr by zero", 48'h00_000000_00_A5, 6, ACK);
    xact("read max", 48'h00_39, 2, 1'b0, 256'hFFFFFF, 3);
    xact("read cnt1", 48'h01_39, 2, 1'b0, 256'h0, 3);
    xact("read cnt2", 48'h02_39, 2, 1'b0, 256'h0, 3);
    nib("bad counter", 48'h03_39, 2, NAK_ARG);
  endtask
  task automatic tMisc();
    // Sink stalls so the 32-byte reply fills the 16-entry reply buffer and stalls the generator
    xact("signature", 48'h00_3C, 2, 1'b0, SIG_TB, 32, 150);
    xact("card type", 48'h4B, 1, 1'b0, 256'h05, 1);
    nib("sig bad arg", 48'h01_3C, 2, NAK_ARG);
    nib("unknown cmd", 48'h60, 1, NAK_ARG);
    xact("crc error", 48'h04_30, 2, 1'b1, 256'h1, -1);
    nib("page out of range", 48'h29_30, 2, NAK_ARG);
  endtask
  task automatic tPages();
    nib("write password", 48'h44332211_27_A2, 6, ACK);
    nib("write ack", 48'h00006655_28_A2, 6, ACK);
    xact("read config", 48'h25_30, 2, 1'b0, 256'h0500_FF000000, 16);
    for (int i = 0; i < 4; i++)
      nib("bad password", PW_BAD, 5, NAK_OTHER);
    check("unlimited", 1'b0, accessLocked);
  endtask
  task automatic tGuard();
    nib("limit two", 48'h00000582_26_A2, 6, ACK);
    nib("start page", 48'h10000000_25_A2, 6, ACK);
    check("protectActive", 1'b1, protectActive);
    nib("write guarded", 48'h0_10_A2, 6, NAK_ARG);
    nib("write below", 48'h0_0F_A2, 6, ACK);
    nib("read guarded", 48'h10_30, 2, NAK_ARG);
    nib("pwd guarded", 48'h44332211_27_A2, 6, NAK_ARG);
    nib("incr unverified", 48'h00_000001_02_A5, 6, ACK);
    xact("read cnt2", 48'h02_39, 2, 1'b0, 256'h1, 3);
    nib("wrong password", PW_BAD, 5, NAK_OTHER);
    check("sessionAuth", 1'b0, sessionAuth);
    xact("right password", PW_OK, 5, 1'b0, 256'h6655, 2);
    check("sessionAuth", 1'b1, sessionAuth);
    nib("write verified", 48'h0_10_A2, 6, ACK);
    nib("pwd verified", 48'h44332211_27_A2, 6, ACK);
    nib("set lock", 48'h00000542_26_A2, 6, ACK);
    nib("pwd after lock", 48'h44332211_27_A2, 6, ACK);
    nib("config locked", 48'h00000542_26_A2, 6, NAK_ARG);
    xact("halt", 48'h00_50, 2, 1'b0, 256'h0, 0);
    check("sessionAuth", 1'b0, sessionAuth);
  endtask
  task automatic tLimit();
    act(8'h52);
    nib("fail once", PW_BAD, 5, NAK_OTHER);
    xact("clear count", PW_OK, 5, 1'b0, 256'h6655, 2);
    xact("halt", 48'h00_50, 2, 1'b0, 256'h0, 0);
    act(8'h52);
    for (int i = 0; i < 2; i++)
      nib("fail to limit", PW_BAD, 5, NAK_OTHER);
    check("lock early", 1'b0, accessLocked);
    nib("fail at limit", PW_BAD, 5, NAK_OTHER);
    check("accessLocked", 1'b1, accessLocked);
    nib("right after lock", PW_OK, 5, NAK_OTHER);
    check("sessionAuth", 1'b0, sessionAuth);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    tReset();
    act(8'h26);
    tCount();
    tMisc();
    tPages();
    tGuard();
    tLimit();
    stopTest();
  end
endmodule
